/* File: core/sdbg_session_ctrl.sv */
// session control and instruction handling of the single-pin debug port
`include "sdbg_cfg.svh"

module sdbg_session_ctrl
  import sdbg_pkg::*;
#(
  parameter int unsigned EN_TO_CYC = `SDBG_EN_TO_CYC,
  parameter int unsigned OE_HOLD_CYC = `SDBG_OE_HOLD_CYC,
  parameter int unsigned SLOW_CYC = `SDBG_SLOW_CYC
) (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic POR_IN,
  input wire logic HV_DETECT_IN,
  input wire logic [1:0] RST_PIN_CFG_IN,
  input wire logic PIN_IN,
  output logic PIN_OUT,
  output logic PIN_OE_N_OUT,
  output logic PIN_DEBUG_MODE_OUT,
  input wire logic GPIO_OE_REQ_IN,
  output logic GPIO_OE_OUT,
  output logic CLK_REQ_OUT,
  output logic [1:0] CLK_SEL_OUT,
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  output sdbg_bus_req_type BUS_REQ_OUT,
  input wire logic [15:0] BUS_RDATA_IN,
  input wire logic BUS_DONE_IN
);
  localparam int CW = 25;
  localparam int OW = $clog2(OE_HOLD_CYC + 1);

  // ============================================================
  // state
  sdbg_state_type st_ff, nxt_st;
  sdbg_phase_type ph_ff, nxt_ph;
  sdbg_bus_req_type bus_ff, nxt_bus;
  logic [CW-1:0] cnt_ff, nxt_cnt, low_cnt_ff, per_ff, nxt_per;
  logic [OW-1:0] oe_cnt_ff;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh, instr_ff, nxt_instr, gcnt_ff, nxt_gcnt;
  logic [11:0] tx_ff, nxt_tx;
  logic [15:0] addr_ff, nxt_addr, data_ff, nxt_data, ptr_ff, nxt_ptr;
  logic [2:0] sig_ff, gt_ff, err_code;
  logic [1:0] clk_ff;
  logic first_ff, nxt_first, bi_ff, nxt_bi, ack_ff, nxt_ack;
  logic hv_mode_ff, hv_prev_ff, pin_prev_ff, pard_ff;
  logic err_set, tmr_start, tmr_half, tick, byte_done;
  logic go_exec, go_bus, go_wr, exec_ack, exec_more;
  logic [15:0] exec_addr;

  // ============================================================
  // decode
  wire logic fall = pin_prev_ff & ~PIN_IN;
  wire logic hv_rise = HV_DETECT_IN & ~hv_prev_ff;
  wire logic dbg_pin = hv_mode_ff | (RST_PIN_CFG_IN == `SDBG_PINCFG_DBG);
  wire logic wr_a = REG_WR_IN & (REG_ADDR_IN == `SDBG_REG_CTRL_A);
  wire logic wr_clk = REG_WR_IN & (REG_ADDR_IN == `SDBG_REG_CLK);
  wire logic wr_pl = REG_WR_IN & (REG_ADDR_IN == `SDBG_REG_PTR_L);
  wire logic wr_ph = REG_WR_IN & (REG_ADDR_IN == `SDBG_REG_PTR_H);
  wire logic wr_dis = REG_WR_IN & (REG_ADDR_IN == `SDBG_REG_CTRL_B) &
                      REG_WDATA_IN[`SDBG_CTRLB_DIS];
  wire logic rd_stat = REG_RD_IN & (REG_ADDR_IN == `SDBG_REG_STAT_B);
  wire logic port_rst = SYS_RST_IN | POR_IN | wr_dis | hv_rise;
  wire logic active = ~(st_ff inside {S_OFF, S_HVRST, S_WAKE});
  // valid sync range scales with the selected debug clock
  wire logic [1:0] sh_amt = (clk_ff == 2'h1) ? 2'h2 :
                            (clk_ff == 2'h2) ? 2'h1 : 2'h0;
  wire logic [CW-1:0] fast_lim = CW'(`SDBG_FAST_CYC) >> sh_amt;
  wire logic [CW-1:0] slow_lim = CW'(SLOW_CYC) >> sh_amt;
  wire logic [CW-1:0] meas_per = cnt_ff >> `SDBG_SYNC_SHIFT;
  wire logic sync_last = fall & (bit_ff == `SDBG_SYNC_LAST);
  wire logic sync_ok = (meas_per >= fast_lim) & (meas_per <= slow_lim);
  wire logic sync_bad = (sync_last & ~sync_ok) |
                        (cnt_ff > (slow_lim << `SDBG_SYNC_SHIFT));
  wire logic [CW-1:0] brk_len = (per_ff << 3) + (per_ff << 2);
  wire logic brk = active & ~PIN_IN & (low_cnt_ff == brk_len);
  wire logic par_bad = ~pard_ff & (^{sh_ff, PIN_IN});
  wire logic [2:0] rop = sh_ff[7:5];
  wire logic [1:0] rasz = sh_ff[3:2];
  wire logic [1:0] rdsz = sh_ff[1:0];
  wire logic sizes_ok = ~rasz[1] & ~rdsz[1];
  wire logic asz_w = instr_ff[2];
  wire logic dsz_w = instr_ff[0];
  wire logic [7:0] gt_bits = (gt_ff == `SDBG_GT_NONE) ? 8'h00 :
                             8'h01 << (3'h7 - gt_ff);
  // low byte goes first; a word's high byte is loaded in S_TXB
  wire logic [7:0] tx_byte = ack_ff ? `SDBG_ACK : data_ff[7:0];
  wire logic [15:0] ptr_base = wr_pl ? {ptr_ff[15:8], REG_WDATA_IN} :
                               wr_ph ? {REG_WDATA_IN, ptr_ff[7:0]} : ptr_ff;
  wire logic [2:0] nxt_sig = err_set ? err_code :
                             rd_stat ? `SDBG_SIG_NONE : sig_ff;
  wire logic oe_done = (oe_cnt_ff == OW'(OE_HOLD_CYC));
  // released pin rests high; waking holds it low
  wire logic drive = ~port_rst & ((nxt_st == S_TXB) | (nxt_st == S_WAKE));
  wire logic nxt_pin = ~drive | ((nxt_st == S_TXB) & nxt_tx[0]);
  wire logic [7:0] rd_val =
    (REG_ADDR_IN == `SDBG_REG_CTRL_A) ? {4'h0, pard_ff, gt_ff} :
    (REG_ADDR_IN == `SDBG_REG_STAT_A) ?
      {5'h00, dbg_pin, st_ff == S_ERR, active} :
    (REG_ADDR_IN == `SDBG_REG_STAT_B) ? {5'h00, sig_ff} :
    (REG_ADDR_IN == `SDBG_REG_CLK) ? {6'h00, clk_ff} :
    (REG_ADDR_IN == `SDBG_REG_PTR_L) ? ptr_ff[7:0] :
    (REG_ADDR_IN == `SDBG_REG_PTR_H) ? ptr_ff[15:8] : 8'h00;

  sdbg_bit_timer #(.W(CW)) u_tmr (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .restart_in(tmr_start),
    .half_in(tmr_half),
    .period_in(per_ff),
    .tick_out(tick)
  );

  assign BUS_REQ_OUT = bus_ff;

  // ============================================================
  // sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_bus = bus_ff;
    nxt_cnt = cnt_ff + CW'(1);
    nxt_per = per_ff;
    nxt_first = first_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_tx = tx_ff;
    nxt_instr = instr_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_ptr = ptr_base;
    nxt_gcnt = gcnt_ff;
    nxt_bi = bi_ff;
    nxt_ack = ack_ff;
    err_set = 1'b0;
    err_code = `SDBG_SIG_NONE;
    tmr_start = 1'b0;
    tmr_half = 1'b0;
    byte_done = 1'b0;
    go_exec = 1'b0;
    go_bus = 1'b0;
    go_wr = 1'b0;
    exec_ack = 1'b0;
    exec_more = 1'b0;
    exec_addr = addr_ff;
    unique case (st_ff)
      S_OFF: if (dbg_pin & fall) begin
        nxt_st = S_WAKE;
        nxt_cnt = '0;
      end
      S_HVRST: if (~HV_DETECT_IN & ~PIN_IN) begin
        nxt_st = S_WAKE;
        nxt_cnt = '0;
      end
      S_WAKE: if (cnt_ff == CW'(`SDBG_WAKE_CYC)) begin
        nxt_st = S_WSYNC;
        nxt_cnt = '0;
        nxt_first = 1'b1;
      end
      S_WSYNC: if (fall) begin
        nxt_st = S_SYNC;
        nxt_cnt = '0;
        nxt_bit = 4'h0;
      end else if (first_ff & (cnt_ff == CW'(EN_TO_CYC))) begin
        nxt_st = S_OFF;
      end
      S_SYNC: begin
        if (fall) nxt_bit = bit_ff + 4'h1;
        if (sync_bad) begin
          nxt_st = first_ff ? S_OFF : S_ERR;
          err_set = ~first_ff;
          err_code = `SDBG_SIG_CLK;
        end else if (sync_last) begin
          nxt_per = meas_per;
          nxt_first = 1'b0;
          nxt_ph = PH_INSTR;
          nxt_st = S_RXW;
        end
      end
      S_RXW: if (fall) begin
        nxt_st = S_RXB;
        nxt_bit = 4'h0;
        tmr_start = 1'b1;
        tmr_half = 1'b1;
      end
      S_RXB: if (tick) begin
        nxt_bit = bit_ff + 4'h1;
        if ((bit_ff == 4'h0) & PIN_IN) begin
          err_set = 1'b1;
          err_code = `SDBG_SIG_START;
        end else if ((bit_ff >= 4'h1) & (bit_ff <= 4'h8)) begin
          nxt_sh = {PIN_IN, sh_ff[7:1]};
        end else if ((bit_ff == 4'h9) & par_bad) begin
          err_set = 1'b1;
          err_code = `SDBG_SIG_PAR;
        end else if ((bit_ff >= 4'ha) & ~PIN_IN) begin
          err_set = 1'b1;
          err_code = `SDBG_SIG_FRAME;
        end else if (bit_ff == 4'hb) begin
          byte_done = 1'b1;
        end
      end
      S_EXEC: begin
        if (tick & (gcnt_ff != 8'h00)) nxt_gcnt = gcnt_ff - 8'h01;
        if (bus_ff.valid) begin
          if (BUS_DONE_IN) begin
            nxt_bus.valid = 1'b0;
            if (~bus_ff.write) nxt_data = BUS_RDATA_IN;
          end else if (cnt_ff == CW'(`SDBG_ACC_TO_CYC)) begin
            err_set = 1'b1;
            err_code = `SDBG_SIG_ACC;
          end
        end else if (gcnt_ff == 8'h00) begin
          nxt_st = S_TXB;
          nxt_tx = {2'b11, ^tx_byte, tx_byte, 1'b0};
          nxt_bit = 4'h0;
          tmr_start = 1'b1;
        end
      end
      S_TXB: if (tick) begin
        if (PIN_IN != tx_ff[0]) begin
          err_set = 1'b1;
          err_code = `SDBG_SIG_CONT;
        end else if (bit_ff != 4'hb) begin
          nxt_tx = {1'b1, tx_ff[11:1]};
          nxt_bit = bit_ff + 4'h1;
        end else if (bi_ff & ~ack_ff) begin
          nxt_bi = 1'b0;
          nxt_tx = {2'b11, ^data_ff[15:8], data_ff[15:8], 1'b0};
          nxt_bit = 4'h0;
        end else if (ack_ff & (ph_ff == PH_ADDR)) begin
          nxt_ack = 1'b0;
          nxt_ph = PH_DATA;
          nxt_bi = 1'b0;
          nxt_st = S_RXW;
        end else begin
          nxt_ack = 1'b0;
          nxt_st = S_WSYNC;
        end
      end
      S_ERR: ;
    endcase
    // handling of each received byte
    if (byte_done) begin
      nxt_st = S_WSYNC;
      unique case (ph_ff)
        PH_INSTR: begin
          nxt_instr = sh_ff;
          nxt_bi = 1'b0;
          if (((rop == `SDBG_OP_LDD) | (rop == `SDBG_OP_STD)) & sizes_ok) begin
            nxt_ph = PH_ADDR;
            nxt_st = S_RXW;
          end else if ((rop == `SDBG_OP_LDI) & ~rdsz[1]) begin
            exec_more = rdsz == `SDBG_SZ_WORD;
            exec_addr = ptr_base;
            if (rasz == `SDBG_PTR_REG) begin
              go_exec = 1'b1;
              nxt_data = ptr_base;
            end else if (~rasz[1]) begin
              go_exec = 1'b1;
              go_bus = 1'b1;
              if (rasz == `SDBG_PTR_INC) begin
                nxt_ptr = ptr_base + (exec_more ? 16'h0002 : 16'h0001);
              end
            end
          end
        end
        PH_ADDR: begin
          nxt_addr = bi_ff ? {sh_ff, addr_ff[7:0]} : {8'h00, sh_ff};
          exec_addr = nxt_addr;
          if (bi_ff == asz_w) begin
            go_exec = 1'b1;
            go_bus = (instr_ff[7:5] == `SDBG_OP_LDD);
            exec_ack = ~go_bus;
            exec_more = go_bus & dsz_w;
          end else begin
            nxt_bi = 1'b1;
            nxt_st = S_RXW;
          end
        end
        PH_DATA: begin
          nxt_data = bi_ff ? {sh_ff, data_ff[7:0]} : {8'h00, sh_ff};
          if (bi_ff == dsz_w) begin
            go_exec = 1'b1;
            go_bus = 1'b1;
            go_wr = 1'b1;
            exec_ack = 1'b1;
          end else begin
            nxt_bi = 1'b1;
            nxt_st = S_RXW;
          end
        end
        default: ;
      endcase
    end
    if (go_exec) begin
      nxt_st = S_EXEC;
      // half bit to the end of the stop bit, then the idle bits
      nxt_gcnt = gt_bits + 8'h01;
      tmr_half = 1'b1;
      nxt_cnt = '0;
      nxt_ack = exec_ack;
      nxt_bi = exec_more;
      nxt_bus.valid = go_bus;
      nxt_bus.write = go_wr;
      nxt_bus.word = go_wr ? dsz_w : exec_more;
      nxt_bus.addr = exec_addr;
      nxt_bus.wdata = nxt_data;
      tmr_start = 1'b1;
    end
    if (err_set) begin
      nxt_st = S_ERR;
      nxt_bus.valid = 1'b0;
    end
    if (brk) begin
      nxt_st = S_WSYNC;
      nxt_first = 1'b0;
      nxt_ack = 1'b0;
      nxt_bus.valid = 1'b0;
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (POR_IN) hv_mode_ff <= 1'b0;
    else if (hv_rise) hv_mode_ff <= 1'b1;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (port_rst) begin
      st_ff <= (hv_rise & ~SYS_RST_IN & ~POR_IN) ? S_HVRST : S_OFF;
      ph_ff <= PH_INSTR;
      bus_ff <= '0;
      cnt_ff <= '0;
      per_ff <= CW'(SLOW_CYC);
      first_ff <= 1'b0;
      ptr_ff <= 16'h0000;
      ack_ff <= 1'b0;
      sig_ff <= `SDBG_SIG_NONE;
      gt_ff <= `SDBG_GT_RST;
      pard_ff <= 1'b0;
      clk_ff <= `SDBG_CLKSEL_RST;
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      bus_ff <= nxt_bus;
      cnt_ff <= nxt_cnt;
      per_ff <= nxt_per;
      first_ff <= nxt_first;
      ptr_ff <= nxt_ptr;
      ack_ff <= nxt_ack;
      sig_ff <= nxt_sig;
      if (wr_a) gt_ff <= REG_WDATA_IN[2:0];
      if (wr_a) pard_ff <= REG_WDATA_IN[`SDBG_CTRLA_PARD];
      if (brk) clk_ff <= `SDBG_CLKSEL_RST;
      else if (wr_clk) clk_ff <= REG_WDATA_IN[1:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    bit_ff <= nxt_bit;
    sh_ff <= nxt_sh;
    tx_ff <= nxt_tx;
    instr_ff <= nxt_instr;
    addr_ff <= nxt_addr;
    data_ff <= nxt_data;
    gcnt_ff <= nxt_gcnt;
    bi_ff <= nxt_bi;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      hv_prev_ff <= 1'b0;
      pin_prev_ff <= 1'b1;
      low_cnt_ff <= '0;
      oe_cnt_ff <= '0;
      PIN_OUT <= 1'b1;
      PIN_OE_N_OUT <= 1'b1;
      PIN_DEBUG_MODE_OUT <= 1'b0;
      GPIO_OE_OUT <= 1'b0;
      CLK_REQ_OUT <= 1'b0;
      CLK_SEL_OUT <= `SDBG_CLKSEL_RST;
      REG_RDATA_OUT <= 8'h00;
    end else begin
      hv_prev_ff <= HV_DETECT_IN;
      pin_prev_ff <= PIN_IN;
      low_cnt_ff <= (active & ~PIN_IN) ? low_cnt_ff + CW'(1) : '0;
      if (~oe_done) oe_cnt_ff <= oe_cnt_ff + OW'(1);
      PIN_OUT <= nxt_pin;
      PIN_OE_N_OUT <= ~drive;
      PIN_DEBUG_MODE_OUT <= dbg_pin;
      GPIO_OE_OUT <= GPIO_OE_REQ_IN & oe_done & ~hv_mode_ff &
                     (RST_PIN_CFG_IN == `SDBG_PINCFG_GPIO);
      CLK_REQ_OUT <= ~port_rst & ~(nxt_st inside {S_OFF, S_HVRST});
      CLK_SEL_OUT <= clk_ff;
      REG_RDATA_OUT <= REG_RD_IN ? rd_val : 8'h00;
    end
  end
endmodule

/* File: core/sdbg_cfg.svh */
// timing counts, register offsets, fields and codes of the debug session block
`ifndef SDBG_CFG_SVH
`define SDBG_CFG_SVH
// ============================================================
// clock and times
`define SDBG_CLK_MHZ 100
`define SDBG_WAKE_US 10
`define SDBG_WAKE_CYC (`SDBG_WAKE_US * `SDBG_CLK_MHZ)
`define SDBG_EN_TO_US 13500
`define SDBG_EN_TO_CYC (`SDBG_EN_TO_US * `SDBG_CLK_MHZ)
`define SDBG_OE_HOLD_US 8800
`define SDBG_OE_HOLD_CYC (`SDBG_OE_HOLD_US * `SDBG_CLK_MHZ)
`define SDBG_ACC_TO_CYC 1000
`define SDBG_MAX_KBPS 225
`define SDBG_FAST_CYC ((`SDBG_CLK_MHZ * 1000) / `SDBG_MAX_KBPS)
`define SDBG_MIN_BPS 75
`define SDBG_SLOW_CYC ((`SDBG_CLK_MHZ * 1000000) / `SDBG_MIN_BPS)
`define SDBG_SYNC_SHIFT 3
`define SDBG_SYNC_LAST 4'h3
// ============================================================
// register offsets and fields
`define SDBG_REG_CTRL_A 3'h0
`define SDBG_REG_CTRL_B 3'h1
`define SDBG_REG_STAT_A 3'h2
`define SDBG_REG_STAT_B 3'h3
`define SDBG_REG_CLK 3'h4
`define SDBG_REG_PTR_L 3'h5
`define SDBG_REG_PTR_H 3'h6
`define SDBG_CTRLA_PARD 3
`define SDBG_CTRLB_DIS 2
`define SDBG_GT_RST 3'h0
`define SDBG_GT_NONE 3'h7
`define SDBG_CLKSEL_RST 2'h3
`define SDBG_PINCFG_GPIO 2'h0
`define SDBG_PINCFG_DBG 2'h1
// ============================================================
// instruction fields and error signatures
`define SDBG_OP_LDD 3'h0
`define SDBG_OP_LDI 3'h1
`define SDBG_OP_STD 3'h2
`define SDBG_SZ_WORD 2'h1
`define SDBG_PTR_INC 2'h1
`define SDBG_PTR_REG 2'h2
`define SDBG_ACK 8'h40
`define SDBG_SIG_NONE 3'h0
`define SDBG_SIG_PAR 3'h1
`define SDBG_SIG_FRAME 3'h2
`define SDBG_SIG_ACC 3'h3
`define SDBG_SIG_CLK 3'h4
`define SDBG_SIG_START 3'h5
`define SDBG_SIG_CONT 3'h6
`endif

/* File: core/sdbg_pkg.sv */
// types shared by the debug session block
package sdbg_pkg;
  typedef enum logic [3:0] {
    S_OFF, S_HVRST, S_WAKE, S_WSYNC, S_SYNC, S_RXW, S_RXB, S_EXEC, S_TXB,
    S_ERR
  } sdbg_state_type;
  typedef enum logic [1:0] {PH_INSTR, PH_ADDR, PH_DATA} sdbg_phase_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sdbg_bus_req_type;
endpackage

/* File: core/sdbg_bit_timer.sv */
// bit period timer giving mid-bit or end-of-bit ticks
module sdbg_bit_timer #(
  parameter int W = 25
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic half_in,
  input wire logic [W-1:0] period_in,
  output logic tick_out
);
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  logic [W-1:0] cnt_ff;
  wire logic [W-1:0] load_val = half_in ? (period_in >> 1) : period_in;
  wire logic expire = (cnt_ff <= ONE);
  wire logic [W-1:0] nxt_cnt = restart_in ? load_val :
                               expire ? period_in : cnt_ff - ONE;
  wire logic nxt_tick = ~restart_in & expire;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_out <= nxt_tick;
    end
  end
endmodule

/* File: tb/sdbg_session_ctrl_sva.sv */
// port assertions of the debug session block
`include "sdbg_cfg.svh"
module sdbg_session_ctrl_sva
  import sdbg_pkg::*;
#(
  parameter int unsigned OE_HOLD_CYC = 200
) (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic POR_IN,
  input wire logic HV_DETECT_IN,
  input wire logic [1:0] RST_PIN_CFG_IN,
  input wire logic PIN_OUT,
  input wire logic PIN_OE_N_OUT,
  input wire logic PIN_DEBUG_MODE_OUT,
  input wire logic GPIO_OE_OUT,
  input wire logic CLK_REQ_OUT,
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire sdbg_bus_req_type BUS_REQ_OUT,
  input wire logic BUS_DONE_IN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rel_cnt_ff;
  logic [15:0] bus_wait_ff;
  wire dis_wr = REG_WR_IN && REG_ADDR_IN == `SDBG_REG_CTRL_B
    && REG_WDATA_IN[`SDBG_CTRLB_DIS];
  wire sig_rd = REG_RD_IN && REG_ADDR_IN == `SDBG_REG_STAT_B;
  // ============================================================
  // cycles since system reset release, saturating
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) rel_cnt_ff <= 32'h0;
    else if (rel_cnt_ff != 32'hffffffff) rel_cnt_ff <= rel_cnt_ff + 32'h1;
  end
  // cycles the bus request has been pending, saturating
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || !BUS_REQ_OUT.valid) bus_wait_ff <= 16'h0;
    else if (bus_wait_ff != 16'hffff) bus_wait_ff <= bus_wait_ff + 16'h1;
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_hv_takes_pin: assert property ($rose(HV_DETECT_IN) && !POR_IN
    |-> ##[1:2] PIN_DEBUG_MODE_OUT) else $error("hv pulse ignored");
  a_hv_pin_kept: assert property (PIN_DEBUG_MODE_OUT && !POR_IN
    && RST_PIN_CFG_IN != `SDBG_PINCFG_DBG |=> PIN_DEBUG_MODE_OUT)
    else $error("debug pin mode lost");
  a_disable_keeps_pin: assert property (dis_wr && PIN_DEBUG_MODE_OUT
    && !POR_IN |-> ##2 PIN_DEBUG_MODE_OUT) else $error("disable freed pin");
  a_disable_drops_clk: assert property (dis_wr
    |-> ##[1:3] !CLK_REQ_OUT) else $error("clock request kept");
  a_gpio_oe_held: assert property (GPIO_OE_OUT
    |-> rel_cnt_ff >= 32'(OE_HOLD_CYC - 1)) else $error("gpio oe early");
  a_gpio_oe_cfg: assert property (GPIO_OE_OUT
    |-> RST_PIN_CFG_IN == `SDBG_PINCFG_GPIO
    && !(PIN_DEBUG_MODE_OUT && $past(PIN_DEBUG_MODE_OUT)))
    else $error("gpio oe in debug mode");
  a_sig_read_clears: assert property (sig_rd ##2 sig_rd
    |=> REG_RDATA_OUT[2:0] == `SDBG_SIG_NONE) else $error("sig kept");
  a_bus_req_steady: assert property (BUS_REQ_OUT.valid && !BUS_DONE_IN
    |=> !BUS_REQ_OUT.valid || $stable(BUS_REQ_OUT)) else $error("req moved");
  a_bus_timeout: assert property (BUS_REQ_OUT.valid
    |-> bus_wait_ff < 16'h3e9) else $error("bus wait unbounded");
  a_idle_high: assert property (PIN_OE_N_OUT |-> PIN_OUT)
    else $error("released pin value low");
endmodule

bind sdbg_session_ctrl sdbg_session_ctrl_sva
  #(.OE_HOLD_CYC(OE_HOLD_CYC)) u_sva (
  .SYS_CLK_IN, .SYS_RST_IN, .POR_IN, .HV_DETECT_IN, .RST_PIN_CFG_IN, .PIN_OUT,
  .PIN_OE_N_OUT, .PIN_DEBUG_MODE_OUT, .GPIO_OE_OUT, .CLK_REQ_OUT, .REG_ADDR_IN,
  .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .BUS_REQ_OUT,
  .BUS_DONE_IN
);

/* File: tb/sdbg_dbg_model.sv */
// debugger model driving the single debug wire
module sdbg_dbg_model (
  input wire logic clk_in,
  input wire logic pin_in,
  output logic drv_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial drv_low_out = 1'b0;
  // released wire floats high on the pull-up
  task automatic hold(input logic v, input int n);
    drv_low_out <= !v;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic send(input logic [7:0] b, input int per, input logic bad);
    logic [11:0] f;
    f = {2'b11, ^b ^ bad, b, 1'b0};
    for (int i = 0; i < 12; i++) hold(f[i], per);
  endtask
  task automatic sync(input int per);
    send(8'h55, per, 1'b0);
  endtask
  task automatic brk(input int per);
    hold(1'b0, 13 * per);
    hold(1'b1, 2 * per);
  endtask
  task automatic recv(input int per, output logic [7:0] b, output logic ok,
                      output int gap);
    logic [11:0] f;
    gap = 0;
    while (pin_in && gap < 40000) begin
      @(posedge clk_in);
      gap++;
    end
    repeat (per / 2) @(posedge clk_in);
    for (int i = 0; i < 12; i++) begin
      f[i] = pin_in;
      if (i < 11) repeat (per) @(posedge clk_in);
    end
    b = f[8:1];
    ok = !f[0] && f[11:10] == 2'b11 && f[9] == ^f[8:1] && gap < 40000;
    hold(1'b1, per);
  endtask
endmodule

/* File: tb/test_single_wire_debug_session_ctrl.sv */
// self-checking bench of the debug session block
`include "sdbg_cfg.svh"
module test_single_wire_debug_session_ctrl;
  import sdbg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 450;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, hv = 1'b0, oe_req = 1'b1;
  logic wr = 1'b0, rd = 1'b0, done = 1'b0, ok, dbg_low, pin_out, oe_n;
  logic dmode, gpio_oe, creq;
  logic [1:0] csel, pcfg = `SDBG_PINCFG_GPIO;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, a, d, b;
  logic [15:0] brd = 16'h0000;
  sdbg_bus_req_type req, last;
  int fail_count = 0, n_checks = 0, bcnt = 0, gap;
  wire pin_w = !(dbg_low || (!oe_n && !pin_out));
  initial forever #5 clk = !clk;
  sdbg_session_ctrl #(.EN_TO_CYC(5000), .OE_HOLD_CYC(200), .SLOW_CYC(4000))
  u_sdbg_session_ctrl (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .POR_IN(por), .HV_DETECT_IN(hv),
    .RST_PIN_CFG_IN(pcfg), .PIN_IN(pin_w), .PIN_OUT(pin_out),
    .PIN_OE_N_OUT(oe_n), .PIN_DEBUG_MODE_OUT(dmode), .GPIO_OE_REQ_IN(oe_req),
    .GPIO_OE_OUT(gpio_oe), .CLK_REQ_OUT(creq), .CLK_SEL_OUT(csel),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .BUS_REQ_OUT(req), .BUS_RDATA_IN(brd),
    .BUS_DONE_IN(done));
  sdbg_dbg_model u_sdbg_dbg_model (.clk_in(clk), .pin_in(pin_w),
    .drv_low_out(dbg_low));
  // ============================================================
  // bus responder: answers each request on its fourth cycle
  always @(posedge clk) begin
    done <= 1'b0;
    bcnt <= (req.valid && !done) ? bcnt + 1 : 0;
    if (req.valid && !done && bcnt == 3) begin
      done <= 1'b1;
      last <= req;
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge clk);
    addr <= ad;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] ad, output logic [7:0] dt);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 dt = rdata;
  endtask
  task automatic wake();
    int n;
    n = 0;
    u_sdbg_dbg_model.hold(1'b0, 20);
    u_sdbg_dbg_model.hold(1'b1, 1);
    while (!pin_w && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("wake", {15'h0, creq && n < 2000}, 16'h1);
  endtask
  initial begin
    void'($urandom(16));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    repeat (150) @(posedge clk);
    chk("gpio_oe_hold", {15'h0, gpio_oe}, 16'h0);
    repeat (110) @(posedge clk);
    chk("gpio_oe_free", {15'h0, gpio_oe}, 16'h1);
    hv <= 1'b1;
    repeat (10000) @(posedge clk);
    hv <= 1'b0;
    repeat (3) @(posedge clk);
    chk("hv_mode", {14'h0, dmode, gpio_oe}, 16'h2);
    $display("test gpio_and_hv done");
    wake();
    repeat (5200) @(posedge clk);
    chk("sync_timeout", {15'h0, creq}, 16'h0);
    wake();
    u_sdbg_dbg_model.sync(100);
    repeat (50) @(posedge clk);
    chk("bad_sync", {15'h0, creq}, 16'h0);
    $display("test auto_disable done");
    wake();
    wreg(`SDBG_REG_CTRL_A, 8'h06);
    a = 8'($urandom);
    brd <= 16'($urandom);
    u_sdbg_dbg_model.sync(P);
    u_sdbg_dbg_model.send({`SDBG_OP_LDD, 5'h00}, P, 1'b0);
    u_sdbg_dbg_model.send(a, P, 1'b0);
    u_sdbg_dbg_model.recv(P, b, ok, gap);
    chk("ldd_data", {7'h0, ok, b}, {8'h01, brd[7:0]});
    chk("ldd_addr", last.addr, {8'h00, a});
    chk("ldd_kind", {14'h0, last.write, last.word}, 16'h0);
    chk("guard", 16'(gap >= 2 * P - 25 && gap <= 2 * P + 25), 16'h1);
    $display("test load_direct done");
    a = 8'($urandom);
    d = 8'($urandom);
    u_sdbg_dbg_model.sync(P);
    u_sdbg_dbg_model.send({`SDBG_OP_STD, 5'h00}, P, 1'b0);
    u_sdbg_dbg_model.send(a, P, 1'b0);
    u_sdbg_dbg_model.recv(P, b, ok, gap);
    chk("std_ack_addr", {7'h0, ok, b}, {8'h01, `SDBG_ACK});
    u_sdbg_dbg_model.send(d, P, 1'b0);
    u_sdbg_dbg_model.recv(P, b, ok, gap);
    chk("std_ack_data", {7'h0, ok, b}, {8'h01, `SDBG_ACK});
    chk("std_addr", last.addr, {8'h00, a});
    chk("std_data", {7'h0, last.write, last.wdata[7:0]}, {8'h01, d});
    $display("test store_direct done");
    d = 8'($urandom);
    wreg(`SDBG_REG_PTR_L, d);
    u_sdbg_dbg_model.sync(P);
    u_sdbg_dbg_model.send(8'h24, P, 1'b0);
    u_sdbg_dbg_model.recv(P, b, ok, gap);
    chk("ldi_data", {7'h0, ok, b}, {8'h01, brd[7:0]});
    chk("ldi_addr", last.addr, {8'h00, d});
    rreg(`SDBG_REG_PTR_L, b);
    chk("ldi_inc", {8'h0, b}, {8'h0, d + 8'h01});
    $display("test load_indirect done");
    wreg(`SDBG_REG_CLK, 8'h01);
    repeat (2) @(posedge clk);
    chk("clk_sel_set", {14'h0, csel}, 16'h1);
    u_sdbg_dbg_model.sync(P);
    u_sdbg_dbg_model.send(8'h00, P, 1'b1);
    repeat (5) @(posedge clk);
    rreg(`SDBG_REG_STAT_A, b);
    chk("err_state", {15'h0, b[1]}, 16'h1);
    u_sdbg_dbg_model.brk(P);
    chk("brk_clk_sel", {14'h0, csel}, {14'h0, `SDBG_CLKSEL_RST});
    u_sdbg_dbg_model.sync(P);
    rreg(`SDBG_REG_STAT_B, b);
    chk("sig_par", {13'h0, b[2:0]}, {13'h0, `SDBG_SIG_PAR});
    rreg(`SDBG_REG_STAT_B, b);
    chk("sig_clear", {8'h0, b}, 16'h0);
    $display("test error_recovery done");
    wreg(`SDBG_REG_CTRL_B, 8'h04);
    repeat (3) @(posedge clk);
    chk("dis", {14'h0, creq, dmode}, 16'h1);
    rreg(`SDBG_REG_CTRL_A, b);
    chk("dis_regs", {8'h0, b}, 16'h0);
    rreg(3'h7, b);
    chk("unmapped", {8'h0, b}, 16'h0);
    oe_req <= 1'b0;
    por <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    repeat (3) @(posedge clk);
    chk("por_frees_pin", {15'h0, dmode}, 16'h0);
    pcfg <= `SDBG_PINCFG_DBG;
    oe_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk("fuse_pin", {14'h0, dmode, gpio_oe}, 16'h2);
    $display("test disable done");
    end_of_test();
  end
endmodule
